//--- pkg/cftc_pkg.sv
// How it works
// R01 - Selects: 00 sleep/standby, 01 go-sleep, 10 power-on stby, 11 normal
// R02 - Sleep releases the inhibit output to high impedance
// R03 - Sleep ties the low-line termination toward battery
// R04 - Sleep with logic supply shows pending wake on receive and flag outputs
// R05 - Standby equals sleep but drives inhibit high
// R06 - Power-on standby shows the battery power-on flag on the flag output
// R07 - Standby to power-on standby keeps inhibit high
// R08 - Sleep to power-on standby keeps inhibit low
// R09 - Wake from either dominant bus line or local wake pulse over 38 us
// R10 - Every recognised wake drives inhibit high
// R11 - Wake levels lasting 38 us or less are ignored
// R12 - Pending wake clears on entering normal mode
// R13 - Faults 3, 4, 7, 8 stay detected in low-power modes
// R14 - Normal: flag low on error, receive low on dominant bit
// R15 - Low termination to logic supply in normal, battery otherwise
// R16 - Current switches closed in normal, open in sleep
// R17 - High-to-battery opens high side; low-to-ground or line short opens low
// R18 - High-to-logic-supply opens high side, low driver stays enabled
// R19 - Low-to-battery opens low termination; high side and drivers stay on
// R20 - Benign faults keep both sides on; low power disables both drivers
// R21 - Pulse-count difference of 4 declares high-to-ground or low-to-supply
// R22 - Low-power mode and flags hold until selects change or wake; a CTRL clear-bit write also clears the power-on flag
`default_nettype none
package cftc_pkg;
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0003;
  localparam int          CTRL_LWAKE    = 0;
  localparam int          CTRL_BWAKE    = 1;
  localparam int          CTRL_PWRCLR   = 2;
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          WAKE_TIME_NS  = 38000;
  localparam logic [10:0] WAKE_CYC      =
    11'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic signed [3:0] PULSE_LIM = 4'sh4;

  typedef enum logic [2:0] {
    CFTC_NORMAL, CFTC_GOSLEEP, CFTC_SLEEP, CFTC_STANDBY, CFTC_PWRON
  } cftc_mode_t;

  // Comparator results from the analog front end, one per fault class
  typedef struct packed {
    logic highToBatt;  // class 3
    logic lowToGnd;    // class 4
    logic lowToBatt;   // class 6
    logic lineShort;   // class 7
    logic highToVcc;   // class 8
  } cftc_fault_t;

  typedef struct packed {
    logic highTermOn;
    logic lowTermOn;
    logic lowTermToBatt;
    logic lowWeakPullupOn;
    logic currentSwOn;
    logic highDrvEn;
    logic lowDrvEn;
  } cftc_sw_t;
endpackage
`default_nettype wire

//--- hw/cftc_ctrl.sv
`default_nettype none
module cftc_ctrl
  import cftc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller side
  input  wire logic        modeSelectA,
  input  wire logic        modeSelectB,
  input  wire logic        rxDominant,
  input  wire logic        vccPresent,
  input  wire logic        battPowerUp,
  output logic             rxdOut,
  output logic             errOutN,
  // Bus and wake side
  input  wire logic        highLineDom,
  input  wire logic        lowLineDom,
  input  wire logic        localWakeN,
  input  wire logic        highPulse,
  input  wire logic        lowPulse,
  input  wire cftc_fault_t faultIn,
  output logic             regulator_inhibit_out,
  output logic             regulatorInhibitOe,
  output cftc_sw_t         switchOut
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  cftc_mode_t        modeFf;
  cftc_mode_t        nxt_mode;
  logic              inhFf;
  logic              nxt_inh;
  logic              wakeFlagFf;
  logic              pwrOnFlagFf;
  logic [10:0]       wakeCntFf;
  logic signed [3:0] pulseDiffFf;
  logic              highGndFf;
  logic              lowVccFf;
  logic [31:0]       ctrlFf;
  logic [31:0]       rdataFf;
  logic              errOutNFf;
  logic              rxdOutFf;
  cftc_sw_t          swFf;
  cftc_sw_t          nxt_sw;
  logic              lowPower;
  logic              wakeLevel;
  logic              wakeHit;
  logic              faultAny;
  logic              pwrClr;
  cftc_fault_t       fAct;

  assign lowPower = (modeFf != CFTC_NORMAL);

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  logic apbWr;
  logic apbSetup;
  logic hitCtrl;
  logic hitStat;

  assign hitCtrl  = (paddr == CTRL_OFS);
  assign hitStat  = (paddr == STAT_OFS);
  assign apbWr    = psel & penable & pwrite;
  assign apbSetup = psel & ~penable;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~(hitCtrl | hitStat);
  assign prdata   = rdataFf;
  assign pwrClr   = apbWr & hitCtrl & pwdata[CTRL_PWRCLR];

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrlFf <= CTRL_RST;
    end else if (apbWr && hitCtrl) begin
      // Clear bit is self-clearing, never stored
      ctrlFf <= {29'h0000_0000, 1'b0, pwdata[CTRL_BWAKE:CTRL_LWAKE]};
    end
  end

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdataFf <= 32'h0000_0000;
    end else if (apbSetup) begin
      if (hitCtrl) begin
        rdataFf <= ctrlFf;
      end else if (hitStat) begin
        rdataFf <= {16'h0000, 1'b0, highGndFf, lowVccFf, faultIn,
                    wakeFlagFf, pwrOnFlagFf, inhFf, 2'b00, modeFf};
      end else begin
        rdataFf <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake filter

  // One shared counter: the sources are ORed, so a bus level followed
  // by a local pulse counts as one continuous request
  assign wakeLevel = lowPower &
                     ((ctrlFf[CTRL_BWAKE] & (highLineDom | lowLineDom)) |
                      (ctrlFf[CTRL_LWAKE] & ~localWakeN)); // R09
  assign wakeHit   = wakeLevel && (wakeCntFf == WAKE_CYC); // R11

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wakeCntFf <= 11'h000;
    end else if (!wakeLevel) begin
      wakeCntFf <= 11'h000;
    end else if (wakeCntFf != WAKE_CYC) begin
      wakeCntFf <= wakeCntFf + 11'h001; // R11
    end
  end

  a_wake_filter: assert property ( // R11
    @(posedge core_clk) disable iff (!rstn)
    $rose(wakeLevel) |-> !wakeHit [*8])
    else $error("wake recognised too early");

  ////////////////////////////////////////////////////////////////////////
  // Mode decode

  always_comb begin
    nxt_mode = modeFf;
    unique case ({modeSelectA, modeSelectB}) // R01
      2'b11: nxt_mode = CFTC_NORMAL;
      2'b01: nxt_mode = CFTC_GOSLEEP;
      2'b10: nxt_mode = CFTC_PWRON;
      2'b00: begin
        // Go-to-sleep or a sleeping origin falls to sleep, else standby
        if (modeFf == CFTC_GOSLEEP || modeFf == CFTC_SLEEP ||
            (modeFf == CFTC_PWRON && !inhFf)) begin
          nxt_mode = CFTC_SLEEP; // R22
        end else begin
          nxt_mode = CFTC_STANDBY;
        end
      end
    endcase
    if (wakeHit && nxt_mode == CFTC_SLEEP) begin
      nxt_mode = CFTC_STANDBY;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      modeFf <= CFTC_STANDBY;
    end else begin
      modeFf <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Regulator inhibit

  always_comb begin
    nxt_inh = inhFf;
    unique case (nxt_mode)
      CFTC_SLEEP:   nxt_inh = 1'b0; // R02
      CFTC_PWRON:   nxt_inh = inhFf; // R07 R08
      default:      nxt_inh = 1'b1; // R05
    endcase
    if (wakeHit) begin
      nxt_inh = 1'b1; // R10
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      inhFf <= 1'b1;
    end else begin
      inhFf <= nxt_inh;
    end
  end

  // Released rather than driven low, so the regulator pulls itself off
  assign regulator_inhibit_out = 1'b1;
  assign regulatorInhibitOe    = inhFf; // R02

  a_sleep_inh_off: assert property ( // R02
    @(posedge core_clk) disable iff (!rstn)
    modeFf == CFTC_SLEEP |-> !regulatorInhibitOe)
    else $error("inhibit driven in sleep");

  a_standby_inh_on: assert property ( // R05
    @(posedge core_clk) disable iff (!rstn)
    modeFf == CFTC_STANDBY |-> inhFf)
    else $error("inhibit low in standby");

  a_pwron_inh_kept: assert property ( // R07 R08
    @(posedge core_clk) disable iff (!rstn)
    modeFf == CFTC_PWRON && $past(modeFf) != CFTC_PWRON && !$past(wakeHit)
    |-> inhFf == $past(inhFf))
    else $error("inhibit changed on power-on standby entry");

  // Entering normal in the same cycle legitimately clears the wake flag
  a_wake_sets_inh: assert property ( // R10
    @(posedge core_clk) disable iff (!rstn)
    wakeHit |=> inhFf && (wakeFlagFf || modeFf == CFTC_NORMAL))
    else $error("wake did not raise inhibit");

  ////////////////////////////////////////////////////////////////////////
  // Wake and power-on flags

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wakeFlagFf <= 1'b0;
    end else if (nxt_mode == CFTC_NORMAL) begin
      wakeFlagFf <= 1'b0; // R12
    end else if (wakeHit) begin
      wakeFlagFf <= 1'b1; // R22
    end
  end

  a_wake_clear: assert property ( // R12
    @(posedge core_clk) disable iff (!rstn)
    modeFf == CFTC_NORMAL |-> !wakeFlagFf)
    else $error("wake flag pending in normal");

  // Reset is a battery power-up, so the flag starts set
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pwrOnFlagFf <= 1'b1;
    end else if (battPowerUp) begin
      pwrOnFlagFf <= 1'b1;
    end else if (pwrClr || nxt_mode == CFTC_NORMAL) begin
      pwrOnFlagFf <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse-count faults, normal mode only

  always_ff @(posedge core_clk) begin
    if (!rstn || lowPower) begin
      pulseDiffFf <= 4'sh0;
    end else if (highPulse && !lowPulse && pulseDiffFf != PULSE_LIM) begin
      pulseDiffFf <= pulseDiffFf + 4'sh1; // R21
    end else if (lowPulse && !highPulse &&
                 pulseDiffFf != -PULSE_LIM) begin
      pulseDiffFf <= pulseDiffFf - 4'sh1; // R21
    end
  end

  // Declared at the limit, released once counts balance again or on leaving normal mode
  always_ff @(posedge core_clk) begin
    if (!rstn || lowPower) begin
      highGndFf <= 1'b0;
      lowVccFf  <= 1'b0;
    end else begin
      if (pulseDiffFf == -PULSE_LIM) begin
        highGndFf <= 1'b1; // R21
      end else if (pulseDiffFf == 4'sh0) begin
        highGndFf <= 1'b0;
      end
      if (pulseDiffFf == PULSE_LIM) begin
        lowVccFf <= 1'b1; // R21
      end else if (pulseDiffFf == 4'sh0) begin
        lowVccFf <= 1'b0;
      end
    end
  end

  a_pulse_fault: assert property ( // R21
    @(posedge core_clk) disable iff (!rstn)
    !lowPower && pulseDiffFf == PULSE_LIM && !$rose(lowPower)
    |=> lowVccFf || lowPower)
    else $error("pulse fault not declared");

  a_pulse_neg: assert property ( // R21
    @(posedge core_clk) disable iff (!rstn)
    !lowPower && pulseDiffFf == -PULSE_LIM |=> highGndFf)
    else $error("negative pulse fault not declared");

  ////////////////////////////////////////////////////////////////////////
  // Switches and drivers

  // Class 6 is only sensed in normal mode
  always_comb begin
    fAct           = faultIn; // R13
    fAct.lowToBatt = faultIn.lowToBatt & ~lowPower;
  end

  assign faultAny = |fAct | highGndFf | lowVccFf;

  always_comb begin
    nxt_sw.highTermOn      = ~(fAct.highToBatt | fAct.highToVcc); // R17 R18
    nxt_sw.lowTermOn       = ~(fAct.lowToGnd | fAct.lineShort |
                               fAct.lowToBatt); // R17 R19
    nxt_sw.lowTermToBatt   = lowPower; // R03 R15
    nxt_sw.lowWeakPullupOn = lowPower &
                             ~(fAct.lowToGnd | fAct.lineShort); // R20
    nxt_sw.currentSwOn     = ~lowPower; // R16
    nxt_sw.highDrvEn       = ~lowPower &
                             ~(fAct.highToBatt | fAct.highToVcc); // R20
    nxt_sw.lowDrvEn        = ~lowPower &
                             ~(fAct.lowToGnd | fAct.lineShort); // R18
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      swFf <= '0;
    end else begin
      swFf <= nxt_sw;
    end
  end

  assign switchOut = swFf;

  a_sleep_switch: assert property ( // R16
    @(posedge core_clk) disable iff (!rstn)
    modeFf == CFTC_SLEEP |=> !switchOut.currentSwOn
                             && switchOut.lowTermToBatt)
    else $error("switches wrong in sleep");

  a_high_short: assert property ( // R17
    @(posedge core_clk) disable iff (!rstn)
    faultIn.highToBatt |=> !switchOut.highDrvEn
                           && !switchOut.highTermOn)
    else $error("high side not opened on short");

  ////////////////////////////////////////////////////////////////////////
  // Receive and flag outputs

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rxdOutFf  <= 1'b1;
      errOutNFf <= 1'b1;
    end else if (!lowPower) begin
      rxdOutFf  <= ~rxDominant; // R14
      errOutNFf <= ~faultAny; // R14
    end else if (!vccPresent) begin
      rxdOutFf  <= 1'b1;
      errOutNFf <= 1'b1;
    end else begin
      rxdOutFf  <= ~wakeFlagFf; // R04
      errOutNFf <= (modeFf == CFTC_PWRON) ? ~pwrOnFlagFf
                                           : ~wakeFlagFf; // R06
    end
  end

  assign rxdOut  = rxdOutFf;
  assign errOutN = errOutNFf;

  a_normal_err: assert property ( // R14
    @(posedge core_clk) disable iff (!rstn)
    !lowPower |=> errOutN == !$past(faultAny)
                  && rxdOut == !$past(rxDominant))
    else $error("normal mode outputs wrong");

endmodule
`default_nettype wire

//--- dv/cftc_bus_model.sv
`default_nettype none
module cftc_bus_model (
  input  wire logic       core_clk,
  input  wire logic       domReq,
  input  wire logic [3:0] pulseNum,
  input  wire logic       pulseGo,
  input  wire logic       pulseOnLow,
  output logic            highLineDom,
  output logic            lowLineDom,
  output logic            highPulse,
  output logic            lowPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pulseLeft_ff = 4'h0;
  logic       pulse_ff     = 1'b0;
  logic       onLow_ff     = 1'b0;

  // A remote node holding the bus dominant pulls both lines
  assign highLineDom = domReq;
  assign lowLineDom  = domReq;
  // One line pulses per burst, so the count difference moves one way
  assign highPulse   = pulse_ff & ~onLow_ff;
  assign lowPulse    = pulse_ff & onLow_ff;

  // Spaced one-cycle pulses; a gap keeps each pulse a separate event
  always_ff @(posedge core_clk) begin
    if (pulseGo) begin
      pulseLeft_ff <= pulseNum;
      onLow_ff     <= pulseOnLow;
      pulse_ff     <= 1'b0;
    end else if (pulseLeft_ff != 4'h0 && !pulse_ff) begin
      pulse_ff     <= 1'b1;
      pulseLeft_ff <= pulseLeft_ff - 4'h1;
    end else begin
      pulse_ff     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- dv/can_transceiver_mode_fault_control_test.sv
`default_nettype none
module can_transceiver_mode_fault_control_test
  import cftc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rstn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic        pready, pslverr, rdErr, rxdOut, errOutN;
  logic        modeSelectA = 1'b0, modeSelectB = 1'b0, rxDominant = 1'b0;
  logic        vccPresent = 1'b1, battPowerUp = 1'b0, localWakeN = 1'b1;
  logic        regulator_inhibit_out, regulatorInhibitOe;
  logic        highLineDom, lowLineDom, highPulse, lowPulse;
  logic        domReq = 1'b0, pulseGo = 1'b0, pulseOnLow = 1'b0;
  logic [3:0]  pulseNum = 4'h0;
  cftc_fault_t faultIn = '0;
  cftc_sw_t    switchOut;
  int          error_cnt = 0, num_checks = 0, cycles = 0;
  logic [4:0]  fltTab [6] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  logic [6:0]  swTab  [6] = '{7'h67, 7'h25, 7'h46, 7'h47, 7'h46, 7'h25};

  cftc_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modeSelectA(modeSelectA), .modeSelectB(modeSelectB),
    .rxDominant(rxDominant), .vccPresent(vccPresent),
    .battPowerUp(battPowerUp), .rxdOut(rxdOut), .errOutN(errOutN),
    .highLineDom(highLineDom), .lowLineDom(lowLineDom),
    .localWakeN(localWakeN), .highPulse(highPulse), .lowPulse(lowPulse),
    .faultIn(faultIn), .regulator_inhibit_out(regulator_inhibit_out),
    .regulatorInhibitOe(regulatorInhibitOe), .switchOut(switchOut));
  cftc_bus_model i_bus (.core_clk(core_clk), .domReq(domReq),
    .pulseNum(pulseNum), .pulseGo(pulseGo), .pulseOnLow(pulseOnLow),
    .highLineDom(highLineDom),
    .lowLineDom(lowLineDom), .highPulse(highPulse), .lowPulse(lowPulse));

  always #10 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  task results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Whole run needs about 5800 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("CHECK FAILED timeout expected 0 seen %0d", cycles);
      results();
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task mode(input logic a, input logic b);
    @(posedge core_clk);
    modeSelectA <= a;
    modeSelectB <= b;
    cyc(3);
  endtask

  task waitInh(output int n);
    n = 0;
    while (regulatorInhibitOe !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    cyc(12);
    rstn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", CTRL_RST, rdData);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("stat", 32'h63, rdData & 32'he7);
    chk("inhOut", 1, regulator_inhibit_out);
    apb(1'b1, 8'h08, 32'h0);
    chk("slverr", 1, rdErr);
    // Status is read only: a write must not move the mode
    apb(1'b1, STAT_OFS, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("statRo", 32'h63, rdData & 32'he7);
    mode(1'b1, 1'b1);
    for (int i = 0; i < 6; i++) begin
      faultIn <= fltTab[i];
      cyc(3);
      chk("swNorm", swTab[i], switchOut & 7'h77);
      chk("errN", i == 0, errOutN);
    end
    faultIn    <= '0;
    rxDominant <= 1'b1;
    cyc(3);
    chk("rxd", 0, rxdOut);
    // Three pulses stay below the limit, the fourth declares the fault
    pulseNum <= 4'h3;
    pulseGo  <= 1'b1;
    cyc(1);
    pulseGo  <= 1'b0;
    cyc(12);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("diff3", 0, rdData[13]);
    pulseNum <= 4'h1;
    pulseGo  <= 1'b1;
    cyc(1);
    pulseGo  <= 1'b0;
    cyc(6);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("diff4", 1, rdData[13]);
    // Eight low-line pulses swing the difference through zero to -4
    pulseOnLow <= 1'b1;
    pulseNum   <= 4'h8;
    pulseGo    <= 1'b1;
    cyc(1);
    pulseGo    <= 1'b0;
    cyc(20);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("diffNeg", 2, rdData[14:13]);
    mode(1'b0, 1'b1);
    mode(1'b0, 1'b0);
    chk("oeSleep", 0, regulatorInhibitOe);
    chk("swSleep", 7'h58, switchOut & 7'h5f);
    faultIn <= 5'h08;
    cyc(3);
    chk("pullup", 0, switchOut.lowWeakPullupOn);
    faultIn    <= '0;
    localWakeN <= 1'b0;
    cyc(1850);
    localWakeN <= 1'b1;
    cyc(5);
    chk("oeShort", 0, regulatorInhibitOe);
    domReq <= 1'b1;
    waitInh(n);
    chk("oeWake", 1, regulatorInhibitOe);
    chk("wakeLen", 1, n > WAKE_CYC);
    domReq <= 1'b0;
    cyc(3);
    chk("rxdWake", 0, rxdOut);
    chk("errWake", 0, errOutN);
    // Without the logic supply both outputs stay released high
    vccPresent <= 1'b0;
    cyc(2);
    chk("rxdNoVcc", 1, rxdOut);
    chk("errNoVcc", 1, errOutN);
    vccPresent <= 1'b1;
    cyc(2);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("statWake", 32'h83, rdData & 32'h87);
    mode(1'b1, 1'b0);
    chk("oePwr", 1, regulatorInhibitOe);
    battPowerUp <= 1'b1;
    cyc(1);
    battPowerUp <= 1'b0;
    cyc(2);
    chk("pwrFlag", 0, errOutN);
    apb(1'b1, CTRL_OFS, 32'h7);
    cyc(2);
    chk("pwrClr", 1, errOutN);
    mode(1'b1, 1'b1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("wakeClr", 0, rdData & 32'hc0);
    mode(1'b0, 1'b1);
    mode(1'b0, 1'b0);
    mode(1'b1, 1'b0);
    chk("oePwrS", 0, regulatorInhibitOe);
    mode(1'b0, 1'b0);
    localWakeN <= 1'b0;
    waitInh(n);
    chk("oeLocal", 1, regulatorInhibitOe);
    localWakeN <= 1'b1;
    results();
  end
endmodule
`default_nettype wire
